/* design/rtc_core.sv */
`timescale 1ns/1ps
`include "rtc_cfg.svh"
// Notes on behaviour
// - separate counts for seconds, minutes, hours, weekday, day, month, year, century.
// - hours run 0 to 23 and wrap, no morning/afternoon bit.
// - one format bit chooses binary or BCD for counts and alarms.
// - day of month rolls at true month length, leap February included.
// - alarm set-points for seconds, minutes, hours, weekday, each enabled.
// - alarm raised only when all enabled fields equal the count.
// - alarm flag always set; interrupt only when interrupt enable is one.
// - reading the control register clears flag and pending interrupt.
// - alarm registers are writable regardless of the unlock bit.
// - alarm compare happens each time the count advances, once a second.
// - writing zero to unlock forces an alarm compare immediately.
// - count source is crystal tick or line signal on oscillator pin.
// - divider turns crystal, 50 Hz or 60 Hz into one advance per second.
// - any control register write resets the seconds divider.
// - after power loss counts undefined and alarm enables cleared.
// - clearing unlock resets divider and restarts counting.
// - unlocked halts counting and opens counts; locked counts, read-only.
// - system reset leaves unlock clear, clock locked and counting.
// - system reset leaves the time count registers untouched.
module rtc_core
    import rtc_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic POR_N_I,
    input wire logic XTAL_TICK_I,
    input wire logic OSC_OUTPUT_PIN_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:2] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic ALARM_IRQ_O
);
    import rtc_pkg::*;

    // time counts: no system reset, kept across RST_N_I
    rtc_pkg::rtc_byte_type sec, min, hrs, dow, dom, mon, yr, cen;
    rtc_pkg::rtc_byte_type a_sec, a_min, a_hrs, a_dow;
    logic [3:0] a_en;
    logic [7:0] ctrl;
    logic alarm_flag;
    logic [15:0] div_cnt;
    logic cmp_pend;
    rtc_bus_state_type bus_state;

    logic unlock;
    logic line_src;
    logic bcd;
    logic line_rise;
    logic src_tick;
    logic [15:0] div_tc;
    logic div_done;
    logic adv;
    logic req;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic rd_ctrl;
    logic wr_cnt;
    logic [7:0] wdat;
    logic match;
    logic [7:0] rdat;
    logic [7:0] dom_last;
    logic sec_wrap;
    logic min_wrap;
    logic hrs_wrap;
    logic dom_wrap;
    logic mon_wrap;
    logic yr_wrap;
    logic wr_sec;
    logic wr_min;
    logic wr_hrs;
    logic wr_dow;
    logic wr_dom;
    logic wr_mon;
    logic wr_yr;
    logic wr_cen;
    logic wr_asec;
    logic wr_amin;
    logic wr_ahrs;
    logic wr_adow;
    logic wr_aen;

    // binary <-> BCD conversion
    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic b);
        logic [7:0] t;
        t = {4'h0, v[7:4]};
        to_bin = b ? 8'((t << 3) + (t << 1) + {4'h0, v[3:0]}) : v;
    endfunction : to_bin

    function automatic logic [7:0] to_fmt(input logic [7:0] v, input logic b);
        logic [7:0] t;
        logic [7:0] u;
        t = v / 8'd10;
        u = v - 8'((t << 3) + (t << 1));
        to_fmt = b ? {t[3:0], u[3:0]} : v;
    endfunction : to_fmt

    // advance a field held in the current format, wrap to lo after hi
    function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic b);
        logic [7:0] n;
        n = to_bin(v, b);
        step = (n >= hi) ? to_fmt(lo, b) : to_fmt(8'(n + 8'h01), b);
    endfunction : step

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y,
                                              input logic [7:0] c);
        logic leap;
        leap = (y[1:0] == 2'b00) && ((y != 8'h00) || (c[1:0] == 2'b00));
        case (m)
            8'h02: month_days = leap ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: month_days = 8'h1E;
            default: month_days = 8'h1F;
        endcase
    endfunction : month_days

    rtc_pin_sync u_line_sync (
        .CORE_CLK_I(CORE_CLK_I),
        .RST_N_I(RST_N_I),
        .pin_i(OSC_OUTPUT_PIN_I),
        .rise_o(line_rise)
    );

    assign unlock = ctrl[`RTC_B_UNLOCK];
    assign line_src = ctrl[`RTC_B_SLOW];
    assign bcd = ctrl[`RTC_B_BCD];
    assign src_tick = line_src ? line_rise : XTAL_TICK_I;
    assign div_tc = !line_src ? `RTC_XTAL_TC :
                    (ctrl[`RTC_B_FREQ_SEL] ? `RTC_L60_TC : `RTC_L50_TC);
    assign div_done = src_tick && (div_cnt == div_tc);
    assign adv = div_done && !unlock;

    assign req = WB_CYC_I && WB_STB_I && (bus_state == RTC_IDLE);
    // writes land at the edge that sees ack high, while the master still holds
    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && (bus_state == RTC_ACK);
    assign rd = req && !WB_WE_I;
    assign wr_ctrl = wr && (WB_ADR_I == `RTC_A_CTRL);
    assign rd_ctrl = rd && (WB_ADR_I == `RTC_A_CTRL);
    assign wr_cnt = wr && unlock && (WB_ADR_I <= `RTC_A_CEN);
    assign wdat = WB_DAT_I[7:0];

    // one write strobe per register
    assign wr_sec = wr_cnt && (WB_ADR_I == `RTC_A_SEC);
    assign wr_min = wr_cnt && (WB_ADR_I == `RTC_A_MIN);
    assign wr_hrs = wr_cnt && (WB_ADR_I == `RTC_A_HRS);
    assign wr_dow = wr_cnt && (WB_ADR_I == `RTC_A_DOW);
    assign wr_dom = wr_cnt && (WB_ADR_I == `RTC_A_DOM);
    assign wr_mon = wr_cnt && (WB_ADR_I == `RTC_A_MON);
    assign wr_yr = wr_cnt && (WB_ADR_I == `RTC_A_YR);
    assign wr_cen = wr_cnt && (WB_ADR_I == `RTC_A_CEN);
    assign wr_asec = wr && (WB_ADR_I == `RTC_A_ASEC);
    assign wr_amin = wr && (WB_ADR_I == `RTC_A_AMIN);
    assign wr_ahrs = wr && (WB_ADR_I == `RTC_A_AHRS);
    assign wr_adow = wr && (WB_ADR_I == `RTC_A_ADOW);
    assign wr_aen = wr && (WB_ADR_I == `RTC_A_ACTRL);

    // carries ripple only on an advance
    assign dom_last = month_days(to_bin(mon, bcd), to_bin(yr, bcd), to_bin(cen, bcd));
    assign sec_wrap = adv && (to_bin(sec, bcd) >= `RTC_MAX_SEC);
    assign min_wrap = sec_wrap && (to_bin(min, bcd) >= `RTC_MAX_SEC);
    assign hrs_wrap = min_wrap && (to_bin(hrs, bcd) >= `RTC_MAX_HRS);
    assign dom_wrap = hrs_wrap && (to_bin(dom, bcd) >= dom_last);
    assign mon_wrap = dom_wrap && (to_bin(mon, bcd) >= `RTC_MAX_MON);
    assign yr_wrap = mon_wrap && (to_bin(yr, bcd) >= `RTC_MAX_YR);

    assign match = (!a_en[0] || a_sec == sec) && (!a_en[1] || a_min == min) &&
                   (!a_en[2] || a_hrs == hrs) && (!a_en[3] || a_dow == dow) &&
                   (a_en != 4'h0);

    always_comb begin
        case (WB_ADR_I)
            `RTC_A_SEC: rdat = sec;
            `RTC_A_MIN: rdat = min;
            `RTC_A_HRS: rdat = hrs;
            `RTC_A_DOW: rdat = {4'h0, dow[3:0]};
            `RTC_A_DOM: rdat = dom;
            `RTC_A_MON: rdat = mon;
            `RTC_A_YR: rdat = yr;
            `RTC_A_CEN: rdat = cen;
            `RTC_A_ASEC: rdat = a_sec;
            `RTC_A_AMIN: rdat = a_min;
            `RTC_A_AHRS: rdat = a_hrs;
            `RTC_A_ADOW: rdat = a_dow;
            `RTC_A_ACTRL: rdat = {4'h0, a_en};
            `RTC_A_CTRL: rdat = {ctrl[7:6], alarm_flag, ctrl[4:0]};
            default: rdat = 8'h00;
        endcase
    end

    // bus slave: ack one cycle after request, then one idle cycle
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bus_state <= RTC_IDLE;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            case (bus_state)
                RTC_IDLE: begin
                    WB_ACK_O <= req;
                    if (req) begin
                        bus_state <= RTC_ACK;
                        WB_DAT_O <= {24'h00_0000, rdat};
                    end
                end
                RTC_ACK: begin
                    WB_ACK_O <= 1'b0;
                    bus_state <= RTC_IDLE;
                end
                default: begin
                    WB_ACK_O <= 1'b0;
                    bus_state <= RTC_IDLE;
                end
            endcase
        end
    end

    // control, divider, alarm flag
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl <= `RTC_CTRL_RST;
            div_cnt <= 16'h0000;
            alarm_flag <= 1'b0;
            cmp_pend <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= {wdat[7:6], 1'b0, wdat[4:0]};
            end
            if (wr_ctrl || unlock) begin
                div_cnt <= 16'h0000;
            end else if (div_done) begin
                div_cnt <= 16'h0000;
            end else if (src_tick) begin
                div_cnt <= 16'(div_cnt + 16'h0001);
            end
            // compare after the count or unlock-clear has settled
            cmp_pend <= adv || (wr_ctrl && !wdat[`RTC_B_UNLOCK]);
            if (cmp_pend && match) begin
                alarm_flag <= 1'b1;
            end else if (rd_ctrl) begin
                alarm_flag <= 1'b0;
            end
        end
    end

    assign ALARM_IRQ_O = alarm_flag && ctrl[`RTC_B_IRQ_EN];

    // alarm registers: power-on reset only, writable at any time
    always_ff @(posedge CORE_CLK_I or negedge POR_N_I) begin
        if (!POR_N_I) begin
            a_en <= 4'h0;
            a_sec <= 8'h00;
            a_min <= 8'h00;
            a_hrs <= 8'h00;
            a_dow <= 8'h00;
        end else begin
            if (wr_asec) begin
                a_sec <= wdat;
            end
            if (wr_amin) begin
                a_min <= wdat;
            end
            if (wr_ahrs) begin
                a_hrs <= wdat;
            end
            if (wr_adow) begin
                a_dow <= {4'h0, wdat[3:0]};
            end
            if (wr_aen) begin
                a_en <= wdat[3:0];
            end
        end
    end

    // time counts: no reset at all, survive RST_N_I
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_sec) begin
            sec <= wdat;
        end else if (adv) begin
            sec <= step(sec, 8'h00, `RTC_MAX_SEC, bcd);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_min) begin
            min <= wdat;
        end else if (sec_wrap) begin
            min <= step(min, 8'h00, `RTC_MAX_SEC, bcd);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_hrs) begin
            hrs <= wdat;
        end else if (min_wrap) begin
            hrs <= step(hrs, 8'h00, `RTC_MAX_HRS, bcd);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_dow) begin
            dow <= {4'h0, wdat[3:0]};
        end else if (hrs_wrap) begin
            dow <= step(dow, 8'h01, `RTC_MAX_DOW, bcd);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_dom) begin
            dom <= wdat;
        end else if (hrs_wrap) begin
            dom <= step(dom, 8'h01, dom_last, bcd);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_mon) begin
            mon <= wdat;
        end else if (dom_wrap) begin
            mon <= step(mon, 8'h01, `RTC_MAX_MON, bcd);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_yr) begin
            yr <= wdat;
        end else if (mon_wrap) begin
            yr <= step(yr, 8'h00, `RTC_MAX_YR, bcd);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_cen) begin
            cen <= wdat;
        end else if (yr_wrap) begin
            cen <= step(cen, 8'h00, `RTC_MAX_YR, bcd);
        end
    end
endmodule : rtc_core

/* design/rtc_cfg.svh */
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// register word addresses (byte address bits [5:2])
`define RTC_A_SEC 4'h0
`define RTC_A_MIN 4'h1
`define RTC_A_HRS 4'h2
`define RTC_A_DOW 4'h3
`define RTC_A_DOM 4'h4
`define RTC_A_MON 4'h5
`define RTC_A_YR 4'h6
`define RTC_A_CEN 4'h7
`define RTC_A_ASEC 4'h8
`define RTC_A_AMIN 4'h9
`define RTC_A_AHRS 4'hA
`define RTC_A_ADOW 4'hB
`define RTC_A_ACTRL 4'hC
`define RTC_A_CTRL 4'hD
// control register bits
`define RTC_B_UNLOCK 0
`define RTC_B_SLOW 1
`define RTC_B_FREQ_SEL 2
`define RTC_B_BCD 3
`define RTC_B_IRQ_EN 4
`define RTC_B_ALARM 5
`define RTC_CTRL_RST 8'h00
// divider terminal counts, minus one
`define RTC_XTAL_HZ 32768
`define RTC_XTAL_TC 16'h7FFF
`define RTC_L50_TC 16'h0031
`define RTC_L60_TC 16'h003B
// field limits in binary
`define RTC_MAX_SEC 8'h3B
`define RTC_MAX_HRS 8'h17
`define RTC_MAX_DOW 8'h07
`define RTC_MAX_MON 8'h0C
`define RTC_MAX_YR 8'h63
`endif

/* design/rtc_pkg.sv */
package rtc_pkg;
    typedef logic [7:0] rtc_byte_type;
    typedef enum logic [1:0] {
        RTC_IDLE = 2'b01,
        RTC_ACK = 2'b10
    } rtc_bus_state_type;
endpackage : rtc_pkg

/* design/rtc_pin_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser with agreement filter
module rtc_pin_sync (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic pin_i,
    output logic rise_o
);
    logic s1;
    logic s2;
    logic s3;
    logic level;
    assign rise_o = (s2 == s3) && s3 && !level;
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule : rtc_pin_sync

/* testbench/rtc_core_checker.sv */
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_core_checker (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:2] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic ALARM_IRQ_O
);
    wire ctrl_req = WB_CYC_I && WB_STB_I && WB_ADR_I == `RTC_A_CTRL;
    wire ctrl_ack = WB_ACK_O && WB_ADR_I == `RTC_A_CTRL;
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    a_ack_next_cycle: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack late");
    a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    a_ack_has_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I) && $past(WB_STB_I))
        else $error("ack without request");
    a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I > 4'hd |->
        WB_DAT_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_irq_flag_match: assert property (ctrl_ack && !WB_WE_I |->
        (WB_DAT_O[5] && WB_DAT_O[4]) == $past(ALARM_IRQ_O)) else $error("irq differs from flag");
    a_irq_masked_off: assert property (ctrl_ack && WB_WE_I && WB_SEL_I[0] && !WB_DAT_I[4]
        |=> !ALARM_IRQ_O) else $error("irq while disabled");
    a_irq_fall_cause: assert property ($fell(ALARM_IRQ_O) |-> $past(ctrl_req))
        else $error("irq dropped without control access");
endmodule : rtc_core_checker
bind rtc_core rtc_core_checker u_checker (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .ALARM_IRQ_O(ALARM_IRQ_O));

/* testbench/rtc_core_tb.sv */
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_core_tb import rtc_pkg::*;;
    logic clk, rst_n, por_n, xtal, pin, cyc, stb, we, ack, irq, bcd;
    logic [3:0] adr, sel;
    logic [31:0] dat_i, dat_o;
    rtc_byte_type q;
    int t[8];
    int num_errors, num_checks;
    always #5 clk = ~clk;
    rtc_core u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .POR_N_I(por_n), .XTAL_TICK_I(xtal),
        .OSC_OUTPUT_PIN_I(pin), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .ALARM_IRQ_O(irq));
    task automatic results();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic chk(input rtc_byte_type seen, input rtc_byte_type want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : chk
    task automatic bus(input logic [3:0] a, input logic w, input rtc_byte_type d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat_i} <= {2'b11, w, a, 4'hf, 24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        q = dat_o[7:0];
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic wr(input logic [3:0] a, input rtc_byte_type d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input rtc_byte_type want);
        bus(a, 1'b0, 8'h00);
        chk(q, want);
    endtask : rd
    function automatic rtc_byte_type enc(input int v);
        return bcd ? 8'(v / 10 * 16 + v % 10) : 8'(v);
    endfunction : enc
    function automatic int mlen();
        if (t[5] == 2) return (t[6] % 4 == 0 && (t[6] > 0 || t[7] % 4 == 0)) ? 29 : 28;
        return (t[5] inside {4, 6, 9, 11}) ? 30 : 31;
    endfunction : mlen
    // reference calendar, binary integers
    task automatic tick();
        int c;
        c = 1;
        for (int i = 0; i < 3; i++) begin
            t[i] += c;
            c = int'(t[i] > (i == 2 ? 23 : 59));
            if (c == 1) t[i] = 0;
        end
        if (c == 1) begin
            t[3] = t[3] % 7 + 1;
            t[4]++;
        end
        if (t[4] > mlen()) begin
            t[4] = 1;
            t[5]++;
        end
    endtask : tick
    task automatic check_time();
        for (int i = 0; i < 8; i++) rd(4'(i), enc(t[i]));
    endtask : check_time
    task automatic set_time(input rtc_byte_type lock);
        wr(`RTC_A_CTRL, 8'(bcd) << 3 | 8'h01);
        for (int i = 0; i < 8; i++) wr(4'(i), enc(t[i]));
        check_time();
        wr(`RTC_A_CTRL, lock);
    endtask : set_time
    task automatic run_second();
        xtal <= 1'b1;
        repeat (32808) @(posedge clk);
        xtal <= 1'b0;
        tick();
        check_time();
    endtask : run_second
    task automatic line_edges(input int k);
        repeat (k) begin
            repeat (8) @(posedge clk);
            pin <= 1'b1;
            repeat (8) @(posedge clk);
            pin <= 1'b0;
        end
        repeat (20) @(posedge clk);
    endtask : line_edges
    initial begin
        {clk, rst_n, por_n, xtal, pin, cyc, stb, we, bcd, adr, sel, dat_i} = '0;
        num_errors = 0;
        num_checks = 0;
        void'($urandom(32'h0000_98fa));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rd(`RTC_A_CTRL, 8'h00);
        rd(`RTC_A_ACTRL, 8'h00);
        rd(4'he, 8'h00);
        t = '{59, 59, 23, 7, 28, 2, 4 * int'($urandom % 24) + 1, 20};
        set_time(8'h10);
        wr(`RTC_A_SEC, 8'h05);
        rd(`RTC_A_SEC, enc(t[0]));
        wr(`RTC_A_ASEC, 8'h00);
        wr(`RTC_A_AMIN, 8'h00);
        wr(`RTC_A_ACTRL, 8'h03);
        chk(8'(irq), 8'h00);
        run_second();
        chk(8'(irq), 8'h01);
        rd(`RTC_A_CTRL, 8'h30);
        @(posedge clk);
        chk(8'(irq), 8'h00);
        wr(`RTC_A_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        chk(8'(irq), 8'h00);
        rd(`RTC_A_CTRL, 8'h20);
        rd(`RTC_A_CTRL, 8'h00);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(`RTC_A_CTRL, 8'h00);
        check_time();
        bcd = 1'b1;
        t = '{59, 59, 23, 7, 28, 2, 24, 20};
        set_time(8'h18);
        wr(`RTC_A_ASEC, 8'h30);
        wr(`RTC_A_ADOW, 8'h01);
        wr(`RTC_A_AHRS, 8'h00);
        rd(`RTC_A_AHRS, 8'h00);
        wr(`RTC_A_ACTRL, 8'h0c);
        run_second();
        chk(8'(irq), 8'h01);
        rd(`RTC_A_CTRL, 8'h38);
        bcd = 1'b0;
        t = '{5, 0, 0, 1, 1, 1, 1, 20};
        set_time(8'h02);
        line_edges(49);
        rd(`RTC_A_SEC, enc(t[0]));
        line_edges(1);
        tick();
        rd(`RTC_A_SEC, enc(t[0]));
        line_edges(30);
        wr(`RTC_A_CTRL, 8'h06);
        line_edges(59);
        rd(`RTC_A_SEC, enc(t[0]));
        line_edges(1);
        tick();
        rd(`RTC_A_SEC, enc(t[0]));
        results();
    end
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule : rtc_core_tb
